// File: frame_tx_seq.v
`timescale 1ns/1ps
module frame_tx_seq (
  // clock and reset
  input  wire       clk_sys,
  input  wire       arst_n,
  // control
  input  wire       start,
  input  wire [8:0] length,
  output wire       busy,
  // byte index to producer
  output wire [8:0] index,
  // link
  output reg        tx_valid,
  input  wire       tx_ready,
  output reg        tx_last
);
  reg [8:0] idx_r;
  reg       act_r;
  assign busy  = act_r;
  assign index = idx_r;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idx_r    <= 9'h000;
      act_r    <= 1'b0;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end else if (!act_r) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      if (start && length != 9'h000) begin
        act_r    <= 1'b1;
        idx_r    <= 9'h000;
        tx_valid <= 1'b1;
        tx_last  <= (length == 9'h001);
      end
    end else if (tx_valid && tx_ready) begin
      if (tx_last) begin
        act_r    <= 1'b0;
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end else begin
        idx_r   <= idx_r + 9'h001;
        tx_last <= (idx_r + 9'h002 == length);
      end
    end
  end
endmodule // frame_tx_seq

// File: mb_func_handler.v
`timescale 1ns/1ps
module mb_func_handler (
  // clock and reset
  input  wire        clk_sys,
  input  wire        arst_n,
  // configuration
  input  wire        cfg_load,
  input  wire [7:0]  cfg_slave,
  output wire [7:0]  slave_addr,
  output wire [31:0] link_baud,
  output wire [3:0]  link_data_bits,
  output wire        link_parity_even,
  output wire [1:0]  link_stop_bits,
  // received frame bytes, crc stripped
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_end,
  input  wire        rx_crc_ok,
  // register map geometry and rights
  input  wire [15:0] map_top_addr,
  input  wire [15:0] map_ro_mask,
  input  wire        dev_fault,
  // register port
  output reg         reg_rd,
  output reg         reg_wr,
  output reg  [15:0] reg_addr,
  output reg  [15:0] reg_wdata,
  input  wire [15:0] reg_rdata,
  // date and time
  output reg         time_load,
  output reg  [63:0] time_value,
  // reply bytes, crc appended downstream
  output wire        tx_valid,
  input  wire        tx_ready,
  output wire [7:0]  tx_data,
  output wire        tx_last
);
`include "mb_func_regs.vh"
  localparam S_RX   = 4'b0001;
  localparam S_EXEC = 4'b0010;
  localparam S_READ = 4'b0100;
  localparam S_TX   = 4'b1000;

  reg  [3:0]  state_r;
  reg  [7:0]  slave_r;
  reg  [7:0]  buf_r [0:255];
  reg  [8:0]  rx_cnt_r;
  reg         ovf_r;
  reg  [7:0]  out_r [0:255];
  reg  [8:0]  out_len_r;
  reg  [7:0]  nregs_r;
  reg  [7:0]  ri_r;
  reg         rd_pend_r;
  reg  [8:0]  wp_r;
  reg  [15:0] cur_addr_r;
  reg         start_r;
  reg  [7:0]  tx_data_r;
  wire        seq_busy;
  wire [8:0]  seq_idx;
  wire        addr_ok;
  wire        acc_ok;
  wire [15:0] chk_addr;
  wire        chk_wr;
  reg  [7:0]  exc_code;
  reg         exc_en;

  function [15:0] word_at;
    input [8:0] p;
    begin
      word_at = {buf_r[p[7:0]], buf_r[p[7:0] + 8'h01]};
    end
  endfunction

  assign slave_addr       = slave_r;
  assign link_baud        = `DEFAULT_BAUD;
  assign link_data_bits   = `DEFAULT_DATA_BITS;
  assign link_parity_even = `DEFAULT_PARITY_EVEN;
  assign link_stop_bits   = `DEFAULT_STOP_BITS;
  assign tx_data          = tx_data_r;

  wire [7:0]  fc    = buf_r[1];
  wire [7:0]  sub   = buf_r[3];
  wire [15:0] start_a = word_at(9'h002);
  wire [7:0]  cnt_lo  = buf_r[5];
  wire [7:0]  cnt_hi  = buf_r[4];
  wire        bcast   = (buf_r[0] == `BROADCAST_ADDR);

  // address for the rights check: the one currently used
  assign chk_addr = cur_addr_r;
  assign chk_wr   = (fc == `FC_WRITE_SINGLE) || (fc == `FC_WRITE_MULTI);

  reg_access_check u_chk (
    .addr       (chk_addr),
    .is_write   (chk_wr),
    .base_addr  (`COMMON_BLOCK_REG - 16'h0001),
    .top_addr   (map_top_addr),
    .ro_mask_lo (map_ro_mask),
    .addr_ok    (addr_ok),
    .access_ok  (acc_ok)
  );

  frame_tx_seq u_seq (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .start    (start_r),
    .length   (out_len_r),
    .busy     (seq_busy),
    .index    (seq_idx),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_last  (tx_last)
  );

  // combinational pre-check of the request
  always @* begin
    exc_en   = 1'b0;
    exc_code = 8'h00;
    if (dev_fault) begin
      exc_en   = 1'b1;
      exc_code = `EXC_DEVICE_FAIL;
    end else if (fc == `FC_READ_HOLD) begin
      if (cnt_hi != 8'h00 || cnt_lo == 8'h00 || cnt_lo > `MAX_READ_REGS) begin
        exc_en   = 1'b1;
        exc_code = `EXC_ILLEGAL_VALUE;
      end
    end else if (fc == `FC_SCATTER) begin
      if (sub != `SUB_SCATTER) begin
        exc_en   = 1'b1;
        exc_code = `EXC_ILLEGAL_FUNC;
      end else if (buf_r[2] < 8'h04 || buf_r[2][0] || ((buf_r[2] - 8'h02) >> 1) > `MAX_READ_REGS) begin
        exc_en   = 1'b1;
        exc_code = `EXC_ILLEGAL_VALUE;
      end
    end else if (fc == `FC_WRITE_SINGLE) begin
      exc_en = 1'b0;
    end else if (fc == `FC_WRITE_MULTI) begin
      if (cnt_hi != 8'h00 || cnt_lo == 8'h00 || cnt_lo > `MAX_READ_REGS
          || buf_r[6] != {cnt_lo[6:0], 1'b0}) begin
        exc_en   = 1'b1;
        exc_code = `EXC_ILLEGAL_VALUE;
      end
    end else if (fc == `FC_DEVICE_MISC) begin
      if (buf_r[2] != `SUB_SET_TIME) begin
        exc_en   = 1'b1;
        exc_code = `EXC_ILLEGAL_FUNC;
      end
    end else begin
      exc_en   = 1'b1;
      exc_code = `EXC_ILLEGAL_FUNC;
    end
  end

  integer k;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= S_RX;
      slave_r    <= `DEFAULT_SLAVE;
      rx_cnt_r   <= 9'h000;
      ovf_r      <= 1'b0;
      out_len_r  <= 9'h000;
      nregs_r    <= 8'h00;
      ri_r       <= 8'h00;
      rd_pend_r  <= 1'b0;
      wp_r       <= 9'h000;
      cur_addr_r <= 16'h0000;
      start_r    <= 1'b0;
      tx_data_r  <= 8'h00;
      reg_rd     <= 1'b0;
      reg_wr     <= 1'b0;
      reg_addr   <= 16'h0000;
      reg_wdata  <= 16'h0000;
      time_load  <= 1'b0;
      time_value <= 64'h0000000000000000;
    end else begin
      start_r   <= 1'b0;
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b0;
      time_load <= 1'b0;
      // reply byte follows the sequencer's next index
      if (start_r && !seq_busy)
        tx_data_r <= out_r[8'h00];
      else if (tx_valid && tx_ready && !tx_last)
        tx_data_r <= out_r[seq_idx[7:0] + 8'h01];
      if (cfg_load && cfg_slave != `BROADCAST_ADDR && cfg_slave <= `MAX_SLAVE)
        slave_r <= cfg_slave;
      case (state_r)
        S_RX: begin
          if (rx_valid) begin
            if (rx_cnt_r < `MAX_FRAME_BYTES - 9'h002) begin
              buf_r[rx_cnt_r[7:0]] <= rx_data;
              rx_cnt_r <= rx_cnt_r + 9'h001;
            end else begin
              ovf_r <= 1'b1;
            end
          end
          if (rx_end) begin
            rx_cnt_r <= 9'h000;
            ovf_r    <= 1'b0;
            if (rx_crc_ok && !ovf_r && rx_cnt_r >= 9'h002
                && (buf_r[0] == slave_r || buf_r[0] == `BROADCAST_ADDR)) begin
              state_r    <= S_EXEC;
              cur_addr_r <= (buf_r[1] == `FC_SCATTER) ? word_at(9'h005) : word_at(9'h002);
            end
          end
        end
        S_EXEC: begin
          out_r[0] <= slave_r;
          if (exc_en) begin
            out_r[1]  <= fc | `EXC_FLAG;
            out_r[2]  <= exc_code;
            out_len_r <= 9'h003;
            state_r   <= S_TX;
          end else if (fc == `FC_DEVICE_MISC) begin
            for (k = 0; k < 8; k = k + 1)
              time_value[63 - 8 * k -: 8] <= buf_r[4 + k];
            time_load <= 1'b1;
            for (k = 1; k < 12; k = k + 1)
              out_r[k] <= buf_r[k];
            out_len_r <= 9'h00C;
            state_r   <= S_TX;
          end else begin
            if (!addr_ok || !acc_ok) begin
              out_r[1]  <= fc | `EXC_FLAG;
              out_r[2]  <= `EXC_ILLEGAL_ADDR;
              out_len_r <= 9'h003;
              state_r   <= S_TX;
            end else begin
              ri_r      <= 8'h00;
              rd_pend_r <= 1'b0;
              out_r[1]  <= fc;
              if (fc == `FC_SCATTER) begin
                nregs_r  <= (buf_r[2] - 8'h02) >> 1;
                out_r[2] <= buf_r[2];
                out_r[3] <= buf_r[3];
                out_r[4] <= buf_r[4];
                wp_r     <= 9'h005;
              end else if (fc == `FC_READ_HOLD) begin
                nregs_r  <= cnt_lo;
                out_r[2] <= {cnt_lo[6:0], 1'b0};
                wp_r     <= 9'h003;
              end else begin
                nregs_r <= (fc == `FC_WRITE_SINGLE) ? 8'h01 : cnt_lo;
                for (k = 2; k < 6; k = k + 1)
                  out_r[k] <= buf_r[k];
                wp_r    <= 9'h006;
              end
              state_r <= S_READ;
            end
          end
        end
        S_READ: begin
          if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            if (fc == `FC_READ_HOLD || fc == `FC_SCATTER) begin
              out_r[wp_r[7:0]]          <= reg_rdata[15:8];
              out_r[wp_r[7:0] + 8'h01]  <= reg_rdata[7:0];
              wp_r <= wp_r + 9'h002;
            end
            ri_r <= ri_r + 8'h01;
            if (fc == `FC_SCATTER)
              cur_addr_r <= word_at({ri_r, 1'b0} + 9'h007);
            else
              cur_addr_r <= cur_addr_r + 16'h0001;
          end else if (ri_r == nregs_r) begin
            out_len_r <= wp_r;
            state_r   <= S_TX;
          end else if (!addr_ok || !acc_ok) begin
            out_r[1]  <= fc | `EXC_FLAG;
            out_r[2]  <= `EXC_ILLEGAL_ADDR;
            out_len_r <= 9'h003;
            state_r   <= S_TX;
          end else begin
            reg_addr  <= cur_addr_r;
            rd_pend_r <= 1'b1;
            if (fc == `FC_WRITE_SINGLE || fc == `FC_WRITE_MULTI) begin
              reg_wr    <= 1'b1;
              reg_wdata <= (fc == `FC_WRITE_SINGLE) ? word_at(9'h004)
                                                    : word_at({ri_r, 1'b0} + 9'h007);
            end else begin
              reg_rd <= 1'b1;
            end
          end
        end
        S_TX: begin
          if (bcast) begin
            state_r <= S_RX;
          end else if (!seq_busy && !start_r) begin
            start_r <= 1'b1;
          end else if (start_r) begin
            start_r <= 1'b0;
          end else begin
            start_r <= 1'b0;
          end
          if (!bcast && seq_busy && tx_valid && tx_ready && tx_last)
            state_r <= S_RX;
        end
        default: state_r <= S_RX;
      endcase
    end
  end
endmodule // mb_func_handler

// File: mb_func_handler_props.sv
`timescale 1ns/1ps
module mb_func_handler_props (
  // clock and reset
  input wire        clk_sys,
  input wire        arst_n,
  // configuration
  input wire        cfg_load,
  input wire [7:0]  cfg_slave,
  input wire [7:0]  slave_addr,
  // request and reply
  input wire        rx_valid,
  input wire [7:0]  rx_data,
  input wire        rx_end,
  input wire        rx_crc_ok,
  input wire        time_load,
  input wire        tx_valid,
  input wire        tx_ready,
  input wire [7:0]  tx_data,
  input wire        tx_last
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // slave number of the frame being received
  reg       first_r;
  reg [7:0] dest_r;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      first_r <= 1'b1;
      dest_r  <= 8'h00;
    end else if (rx_end) begin
      first_r <= 1'b1;
    end else if (rx_valid && first_r) begin
      first_r <= 1'b0;
      dest_r  <= rx_data;
    end
  end
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed while stalled");
  AST_CRC_DROP: assert property (rx_end && !rx_crc_ok |=> !tx_valid [*8])
    else $error("reply to corrupted frame");
  AST_BCAST: assert property (rx_end && rx_crc_ok && dest_r == 8'h00 |=> !tx_valid [*8])
    else $error("reply to broadcast");
  AST_FOREIGN: assert property (rx_end && dest_r != 8'h00 && dest_r != slave_addr |=> !tx_valid [*8])
    else $error("reply to other slave");
  AST_ANSWER: assert property (rx_end && rx_crc_ok && dest_r == slave_addr |-> ##[1:400] tx_valid)
    else $error("no reply to own request");
  AST_FIRST_BYTE: assert property ($rose(tx_valid) |-> tx_data == slave_addr)
    else $error("reply does not start with slave number");
  AST_RESET_SLAVE: assert property ($rose(arst_n) |-> slave_addr == 8'h01)
    else $error("slave number not 1 after reset");
  AST_CFG: assert property (cfg_load && cfg_slave != 8'h00 && cfg_slave <= 8'hF7 |=> slave_addr == $past(cfg_slave))
    else $error("slave number not loaded");
  AST_CFG_BAD: assert property (cfg_load && (cfg_slave == 8'h00 || cfg_slave > 8'hF7) |=> $stable(slave_addr))
    else $error("illegal slave number taken");
  AST_TIME_PULSE: assert property (time_load |=> !time_load)
    else $error("time load longer than one cycle");
  cover property (rx_end && rx_crc_ok ##[1:400] tx_last && tx_ready);
  cover property (rx_end && !rx_crc_ok);
  cover property (time_load);
endmodule // mb_func_handler_props

// File: mb_func_regs.vh
`ifndef MB_FUNC_REGS_VH
`define MB_FUNC_REGS_VH
`define FC_READ_HOLD      8'h03
`define FC_WRITE_SINGLE   8'h06
`define FC_WRITE_MULTI    8'h10
`define FC_DEVICE_MISC    8'h2B
`define FC_SCATTER        8'h64
`define SUB_SET_TIME      8'h10
`define SUB_SCATTER       8'h04
`define EXC_FLAG          8'h80
`define EXC_ILLEGAL_FUNC  8'h01
`define EXC_ILLEGAL_ADDR  8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define EXC_DEVICE_FAIL   8'h04
`define MAX_READ_REGS     8'h7D
`define MAX_FRAME_BYTES   9'h100
`define BROADCAST_ADDR    8'h00
`define DEFAULT_SLAVE     8'h01
`define MAX_SLAVE         8'hF7
`define COMMON_BLOCK_REG  16'h03E9
`define DEFAULT_BAUD      32'd19200
`define DEFAULT_DATA_BITS 4'h8
`define DEFAULT_STOP_BITS 2'h2
`define DEFAULT_PARITY_EVEN 1'b1
`define TIME_BYTES        8'h08
`endif

// File: reg_access_check.v
`timescale 1ns/1ps
module reg_access_check (
  // lookup
  input  wire [15:0] addr,
  input  wire        is_write,
  input  wire [15:0] base_addr,
  input  wire [15:0] top_addr,
  input  wire [15:0] ro_mask_lo,
  // result
  output wire        addr_ok,
  output wire        access_ok
);
`include "mb_func_regs.vh"
  wire in_range;
  wire in_mask_win;
  assign in_range    = (addr >= base_addr) && (addr <= top_addr);
  assign in_mask_win = (addr - base_addr) < 16'h0010;
  assign addr_ok     = in_range;
  assign access_ok   = !is_write || !(in_mask_win && ro_mask_lo[addr[3:0] - base_addr[3:0]]);
endmodule // reg_access_check

// File: reg_map_model.sv
`timescale 1ns/1ps
module reg_map_model (
  // register port
  input  wire        clk_sys,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // reply side
  input  wire        slow,
  output reg         tx_ready
);
  reg     [15:0] mem [0:15];
  wire    [15:0] idx = reg_addr - 16'h03E8;
  integer        i;
  initial begin
    for (i = 0; i < 16; i = i + 1)
      mem[i] = 16'hC000 + i;
    tx_ready = 1'b0;
  end
  // read data stands while reg_rd is high, garbage otherwise
  always @* begin
    reg_rdata = reg_rd ? mem[idx[3:0]] : ~mem[idx[3:0]];
  end
  always @(posedge clk_sys) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (reg_wr)
      mem[idx[3:0]] <= reg_wdata;
  end
endmodule // reg_map_model

// File: test_mb_func_handler.sv
`timescale 1ns/1ps
`define CHK(g, e) chk((g), (e))
module test_mb_func_handler;
  typedef logic [7:0] bq_t[$];
  reg         clk_sys = 1'b0;
  reg         arst_n = 1'b0;
  reg         cfg_load = 1'b0;
  reg  [7:0]  cfg_slave = 8'h00;
  reg         rx_valid = 1'b0;
  reg  [7:0]  rx_data = 8'h00;
  reg         rx_end = 1'b0;
  reg         rx_crc_ok = 1'b0;
  reg         dev_fault = 1'b0;
  reg         slow = 1'b0;
  wire [7:0]  slave_addr, tx_data;
  wire [31:0] link_baud;
  wire [3:0]  link_data_bits;
  wire [1:0]  link_stop_bits;
  wire [15:0] reg_addr, reg_wdata, reg_rdata;
  wire [63:0] time_value;
  wire        link_parity_even, reg_rd, reg_wr, time_load, tx_valid, tx_ready, tx_last;
  integer     err_count = 0;
  integer     n_tests = 0;
  bq_t        r;
  mb_func_handler dut (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_load(cfg_load), .cfg_slave(cfg_slave),
    .slave_addr(slave_addr), .link_baud(link_baud), .link_data_bits(link_data_bits),
    .link_parity_even(link_parity_even), .link_stop_bits(link_stop_bits), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .map_top_addr(16'h03F7),
    .map_ro_mask(16'h0003), .dev_fault(dev_fault), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .time_load(time_load),
    .time_value(time_value), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
  reg_map_model model (.clk_sys(clk_sys), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slow(slow), .tx_ready(tx_ready));
  always #5 clk_sys = ~clk_sys;
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input [63:0] g, input [63:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // send one request, collect the reply or time out
  task xfer(input bq_t q, input logic ok);
    integer w;
    r = {};
    foreach (q[k]) begin
      rx_data = q[k];
      rx_valid = 1'b1;
      tick;
      rx_valid = 1'b0;
      tick;
    end
    rx_crc_ok = ok;
    rx_end = 1'b1;
    tick;
    rx_end = 1'b0;
    for (w = 0; w < 500; w = w + 1) begin
      if (tx_valid && tx_ready) begin
        r.push_back(tx_data);
        if (tx_last)
          w = 500;
      end
      tick;
    end
  endtask
  task cmp(input bq_t e);
    `CHK(r.size(), e.size());
    foreach (e[k])
      if (k < r.size()) `CHK(r[k], e[k]);
  endtask
  task exc(input bq_t q, input [7:0] fc, input [7:0] code);
    xfer(q, 1'b1);
    cmp('{8'h2F, fc, code});
  endtask
  task s_reset_cfg;
    `CHK(slave_addr, 8'h01);
    `CHK({link_baud, link_data_bits, link_parity_even, link_stop_bits}, {32'd19200, 4'h8, 1'b1, 2'h2});
    xfer('{8'h01, 8'h03, 8'h03, 8'hE8, 8'h00, 8'h01}, 1'b1);
    cmp('{8'h01, 8'h03, 8'h02, 8'hC0, 8'h00});
    cfg_slave = 8'hF8;
    cfg_load = 1'b1;
    tick;
    cfg_slave = 8'h2F;
    tick;
    cfg_load = 1'b0;
    `CHK(slave_addr, 8'h2F);
  endtask
  task s_read;
    slow = 1'b1;
    xfer('{8'h2F, 8'h03, 8'h03, 8'hEA, 8'h00, 8'h02}, 1'b1);
    cmp('{8'h2F, 8'h03, 8'h04, 8'hC0, 8'h02, 8'hC0, 8'h03});
    slow = 1'b0;
    xfer('{8'h2F, 8'h64, 8'h06, 8'h04, 8'h5A, 8'h03, 8'hF0, 8'h03, 8'hEC}, 1'b1);
    cmp('{8'h2F, 8'h64, 8'h06, 8'h04, 8'h5A, 8'hC0, 8'h08, 8'hC0, 8'h04});
  endtask
  task s_exceptions;
    exc('{8'h2F, 8'h03, 8'h03, 8'hE8, 8'h00, 8'h00}, 8'h83, 8'h03);
    exc('{8'h2F, 8'h03, 8'h03, 8'hE8, 8'h00, 8'h7E}, 8'h83, 8'h03);
    exc('{8'h2F, 8'h03, 8'h04, 8'h00, 8'h00, 8'h01}, 8'h83, 8'h02);
    exc('{8'h2F, 8'h07, 8'h00, 8'h00}, 8'h87, 8'h01);
    exc('{8'h2F, 8'h06, 8'h03, 8'hE8, 8'h00, 8'h05}, 8'h86, 8'h02);
    dev_fault = 1'b1;
    exc('{8'h2F, 8'h03, 8'h03, 8'hE8, 8'h00, 8'h01}, 8'h83, 8'h04);
    dev_fault = 1'b0;
  endtask
  task s_write;
    xfer('{8'h2F, 8'h06, 8'h03, 8'hEC, 8'h12, 8'h34}, 1'b1);
    cmp('{8'h2F, 8'h06, 8'h03, 8'hEC, 8'h12, 8'h34});
    xfer('{8'h2F, 8'h10, 8'h03, 8'hED, 8'h00, 8'h02, 8'h04, 8'hAB, 8'hCD, 8'h00, 8'h01}, 1'b1);
    cmp('{8'h2F, 8'h10, 8'h03, 8'hED, 8'h00, 8'h02});
    xfer('{8'h00, 8'h06, 8'h03, 8'hEE, 8'h55, 8'h66}, 1'b1);
    `CHK(r.size(), 0);
    xfer('{8'h30, 8'h06, 8'h03, 8'hEF, 8'h77, 8'h88}, 1'b1);
    `CHK(r.size(), 0);
    xfer('{8'h2F, 8'h06, 8'h03, 8'hEF, 8'h77, 8'h88}, 1'b0);
    `CHK(r.size(), 0);
    xfer('{8'h2F, 8'h03, 8'h03, 8'hEC, 8'h00, 8'h04}, 1'b1);
    cmp('{8'h2F, 8'h03, 8'h08, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'h55, 8'h66, 8'hC0, 8'h07});
  endtask
  task s_time;
    xfer('{8'h2F, 8'h2B, 8'h10, 8'h00, 8'h00, 8'h0E, 8'h0A, 8'h02, 8'h0E, 8'h20, 8'h0D, 8'hAC}, 1'b1);
    cmp('{8'h2F, 8'h2B, 8'h10, 8'h00, 8'h00, 8'h0E, 8'h0A, 8'h02, 8'h0E, 8'h20, 8'h0D, 8'hAC});
    `CHK(time_value, 64'h000E0A020E200DAC);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    tick;
    s_reset_cfg;
    s_read;
    s_exceptions;
    s_write;
    s_time;
    give_verdict;
  end
  initial begin
    #500000;
    err_count = err_count + 1;
    give_verdict;
  end
endmodule // test_mb_func_handler
bind mb_func_handler mb_func_handler_props chk (.clk_sys, .arst_n, .cfg_load, .cfg_slave, .slave_addr,
  .rx_valid, .rx_data, .rx_end, .rx_crc_ok, .time_load, .tx_valid, .tx_ready, .tx_data, .tx_last);
